// >>> pkg/osd_fx_pkg.sv
// Purpose: shared constants and types for the osd effect and dot clock pll control
// Assumes: 100 MHz system clock, 16-bit frame control registers
// Notes: register offsets are byte addresses on the plain register port
package osd_fx_pkg;
  localparam int CLK_MHZ = 100; // system clock rate
  localparam int ADDR_W = 8; // register address width
  localparam int DATA_W = 16; // register data width
  // register map
  localparam logic [7:0] REG_FC0 = 8'h00; // frame control 0: effects
  localparam logic [7:0] REG_FC1 = 8'h04; // frame control 1: pll control
  localparam logic [7:0] REG_STAT = 8'h08; // status, read only
  localparam logic [15:0] FC0_RST = 16'h0000; // reset value of frame control 0
  localparam logic [15:0] FC1_RST = 16'h0000; // reset value of frame control 1
  // frame control 0 fields
  localparam int DISP_ON_BIT = 0; // osd display on
  localparam int FADE_EN_BIT = 1; // fade in/out active
  localparam int FADE_TIME_BIT = 2; // fade_time_select
  localparam int SCROLL_EN_BIT = 3; // scrolling mode
  localparam int BORDER_BIT = 4; // black bordering
  localparam int SHADOW_BIT = 5; // black shadowing
  // frame control 1 fields
  localparam int DOT_LSB = 8; // pixels_per_line_sel [9:8]
  localparam int HF_LSB = 10; // line_rate_range_sel [12:10]
  localparam int CP_LSB = 13; // pump_current_sel [14:13]
  localparam int AUX_BIT = 15; // pll_aux_select
  // character cell geometry
  localparam logic [3:0] EDGE_COL_FIRST = 4'h0; // first dot of a 12-dot cell
  localparam logic [3:0] EDGE_COL_LAST = 4'hb; // twelfth dot
  localparam logic [4:0] EDGE_LINE_FIRST = 5'h00; // first line of an 18-line cell
  localparam logic [4:0] EDGE_LINE_LAST = 5'h11; // eighteenth line
  localparam logic [4:0] CELL_LINES = 5'h12; // lines per cell
  // fade pacing in vertical pulses per step
  localparam logic [3:0] FADE_DIV_SHORT = 4'h4; // half second fade
  localparam logic [3:0] FADE_DIV_LONG = 4'h8; // one second fade
  // flyback lock range
  localparam int LINE_MIN_KHZ = 15; // slowest flyback rate
  localparam int LINE_MAX_KHZ = 90; // fastest flyback rate
  localparam int LINE_MIN_CYC = (CLK_MHZ * 1000 + LINE_MAX_KHZ - 1) / LINE_MAX_KHZ;
  localparam int LINE_MAX_CYC = (CLK_MHZ * 1000) / LINE_MIN_KHZ;
  // feedback divider ratios
  localparam logic [9:0] DIV_320 = 10'h140;
  localparam logic [9:0] DIV_480 = 10'h1e0;
  localparam logic [9:0] DIV_640 = 10'h280;
  localparam logic [9:0] DIV_800 = 10'h320;
  typedef enum logic [1:0] {PFD_IDLE, PFD_UP, PFD_DOWN} pfd_state_e;
endpackage

// >>> pkg/pll_if.sv
// Purpose: signals between the effect top and the pll divider/phase detector
// Assumes: one clock, the pixel clock
// Notes: ctrl is the top side, pfd the divider side
`timescale 1ns/10ps
`default_nettype none
interface pll_if;
  logic ref_edge; // one-cycle pulse on flyback rising edge
  logic [1:0] dot_sel; // pixels_per_line_sel
  logic div_tick; // one-cycle pulse, divider wrap
  logic pump_src; // pump level when driving: 1 source, 0 sink
  logic pump_oe; // pump driving, low means high impedance
  modport ctrl (output ref_edge, output dot_sel, input div_tick, input pump_src,
    input pump_oe);
  modport pfd (input ref_edge, input dot_sel, output div_tick, output pump_src,
    output pump_oe);
endinterface
`default_nettype wire

// >>> logic/dot_pll_ctrl.sv
// Purpose: pll feedback divider and three-state phase/frequency detector
// Assumes: clk is the vco output, ref_edge already synchronised
// Notes: the divider runs free so the loop closes through the analog vco
`timescale 1ns/10ps
`default_nettype none
module dot_pll_ctrl (
  input wire logic clk,
  input wire logic rst_n,
  pll_if.pfd pll
);
  import osd_fx_pkg::*;

  typedef struct packed {
    logic [9:0] cnt; // dots into the line
    logic div_tick; // divider wrap pulse
    pfd_state_e st; // detector state
    logic src; // pump sources current
    logic oe; // pump drives
  } pll_s;

  pll_s q, d;
  logic [9:0] ratio; // active divide ratio

  // ratio from the two dot select bits
  always_comb begin
    unique case (pll.dot_sel)
      2'h0: ratio = DIV_320;
      2'h1: ratio = DIV_480;
      2'h2: ratio = DIV_640;
      2'h3: ratio = DIV_800;
    endcase
  end

  // divider and detector next state
  always_comb begin
    d = q;
    d.div_tick = 1'b0;
    if (q.cnt >= ratio - 10'h001) begin // wrap also catches a ratio shrunk mid-line
      d.cnt = 10'h000; // R10
      d.div_tick = 1'b1; // R13
    end else begin
      d.cnt = q.cnt + 10'h001;
    end
    unique case (q.st)
      PFD_IDLE: begin
        if (pll.ref_edge && !q.div_tick) d.st = PFD_UP;
        else if (q.div_tick && !pll.ref_edge) d.st = PFD_DOWN;
      end
      PFD_UP: if (q.div_tick) d.st = PFD_IDLE; // reference led, feedback caught up
      PFD_DOWN: if (pll.ref_edge) d.st = PFD_IDLE; // feedback led, reference caught up
      default: d.st = PFD_IDLE; // illegal code recovers
    endcase
    d.oe = (d.st != PFD_IDLE); // R14
    d.src = (d.st == PFD_UP); // R14
  end

  // state register
  always_ff @(posedge clk) begin
    if (!rst_n) q <= '{cnt: 10'h000, div_tick: 1'b0, st: PFD_IDLE, src: 1'b0, oe: 1'b0};
    else q <= d;
  end

  assign pll.div_tick = q.div_tick;
  assign pll.pump_src = q.src;
  assign pll.pump_oe = q.oe;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  pump_sink_a: assert property ((q.st == PFD_IDLE) && q.div_tick && !pll.ref_edge // R14
    |=> q.oe && !q.src) else $error("feedback lead did not sink");
  pump_source_a: assert property ((q.st == PFD_IDLE) && pll.ref_edge && !q.div_tick // R14
    |=> q.oe && q.src) else $error("reference lead did not source");
  pump_hiz_a: assert property ((q.st == PFD_IDLE) && (pll.ref_edge == q.div_tick) // R14
    |=> !q.oe) else $error("in-phase pump not high impedance");
  div_spacing_a: assert property (q.div_tick |=> !q.div_tick [*8]) // R10
    else $error("divider ticks too close");
endmodule // dot_pll_ctrl
`default_nettype wire

// >>> logic/osd_fx_top.sv
// Purpose: osd cell effects, fade and scroll pacing, pll control registers
// Assumes: CLOCK is the pll vco output; cell and glyph inputs come from same-clock logic
// Notes: flyback and vertical pulse pins pass a three-stage synchroniser
//
// What this block does
// [R1] box edges on cell dots 1,12, lines 1,18
// [R2] border and shadow are black only
// [R3] border: one black pixel around glyph
// [R4] shadow: black pixel right and below glyph
// [R5] scroll reveals or erases cell top-down
// [R6] fade opens cells from centre outward
// [R7] fade takes 0.5 s or 1 s
// [R8] fade steps every 4 or 8 vertical pulses
// [R9] flyback is pll reference, 15-90 kHz
// [R10] dot select picks divide 320/480/640/800
// [R11] line rate range from control 1 bits C-A
// [R12] pump current from control 1 bits E-D
// [R13] vco clocks osd timing and divider
// [R14] pump sinks, sources or floats by phase
// [R15] host writes recommended pll control byte
// [R16] one ring of cells per fade step
//
// The address map and the plain strobed port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module osd_fx_top #(
  parameter int COLS = 30, // cell columns on screen
  parameter int ROWS = 15, // cell rows on screen
  parameter int MAX_LINE_CYC = osd_fx_pkg::LINE_MAX_CYC, // slowest legal line, cycles
  parameter int MIN_LINE_CYC = osd_fx_pkg::LINE_MIN_CYC // fastest legal line, cycles
) (
  input wire logic CLOCK,
  input wire logic RESETN,
  input wire logic [osd_fx_pkg::ADDR_W-1:0] ADDR,
  input wire logic [osd_fx_pkg::DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [osd_fx_pkg::DATA_W-1:0] RDATA,
  input wire logic HORIZ_FLYBACK_REF,
  input wire logic VERT_PULSE,
  input wire logic PIXEL_VALID,
  input wire logic BOX_ENABLE,
  input wire logic [3:0] CELL_COL,
  input wire logic [4:0] CELL_LINE,
  input wire logic [5:0] CELL_X,
  input wire logic [4:0] CELL_Y,
  input wire logic [11:0] GLYPH_ABOVE,
  input wire logic [11:0] GLYPH_ROW,
  input wire logic [11:0] GLYPH_BELOW,
  output logic PIXEL_LIT,
  output logic PIXEL_BLACK,
  output logic BOX_EDGE,
  output logic CELL_VISIBLE,
  output logic [2:0] LINE_RATE_RANGE_SEL,
  output logic [1:0] PUMP_CURRENT_SEL,
  output logic PLL_AUX_SELECT,
  output logic PUMP_OUTPUT_O,
  output logic PUMP_OUTPUT_OE
);
  import osd_fx_pkg::*;

  localparam int RING_W = 6; // ring counter width
  localparam logic [RING_W-1:0] MAX_RING =
    RING_W'(((COLS > ROWS) ? COLS : ROWS) / 2 + 1); // radius that shows every cell
  localparam int CNT_W = $clog2(MAX_LINE_CYC + 2); // line period counter width
  localparam logic [CNT_W-1:0] LINE_HI = CNT_W'(MAX_LINE_CYC); // longest legal period
  localparam logic [CNT_W-1:0] LINE_LO = CNT_W'(MIN_LINE_CYC); // shortest legal period

  // distance of a cell index from the screen centre, in cells
  function automatic logic [RING_W-1:0] ring_dist(input logic [5:0] pos, input int n);
    logic [5:0] c;
    c = 6'(n / 2);
    if (pos >= c) ring_dist = RING_W'(pos - c);
    else ring_dist = RING_W'(c - 6'h01 - pos);
  endfunction

  typedef struct packed {
    logic [15:0] fc0; // frame control 0
    logic [15:0] fc1; // frame control 1
    logic [15:0] rdata; // read answer
    logic [2:0] hf_s; // flyback synchroniser chain
    logic hf_f; // flyback after agreement filter
    logic [2:0] vp_s; // vertical pulse synchroniser chain
    logic vp_f; // vertical pulse after agreement filter
    logic ref_edge; // flyback rising edge pulse
    logic [CNT_W-1:0] line_cnt; // cycles since last flyback edge
    logic line_ok; // last line period within lock range
    logic disp_prev; // display bit last cycle
    logic [RING_W-1:0] radius; // cells with ring below this are shown
    logic [3:0] fade_div; // vertical pulses since last fade step
    logic [4:0] scroll; // lines done in current scroll
    logic lit; // pixel output regs
    logic black;
    logic box;
    logic vis;
  } top_s;

  top_s q, d;
  pll_if pll ();

  logic vp_edge; // vertical pulse rising edge
  logic [RING_W-1:0] ring; // ring of the current cell
  logic [RING_W-1:0] fade_target; // radius the fade walks toward
  logic [3:0] fade_ratio; // vertical pulses per fade step
  logic scroll_vis; // current line passes the scroll window
  logic glyph_on; // current dot of glyph
  logic near_border; // a neighbour dot is lit
  logic near_shadow; // left, upper or upper-left dot is lit
  logic [13:0] wide_above, wide_row, wide_below; // glyph rows padded by one dot each side
  logic [3:0] col_i; // padded column index of current dot

  // glyph neighbourhood; dots left and right of the cell count as dark, so effects stop at its side edges
  always_comb begin
    wide_above = {1'b0, GLYPH_ABOVE, 1'b0};
    wide_row = {1'b0, GLYPH_ROW, 1'b0};
    wide_below = {1'b0, GLYPH_BELOW, 1'b0};
    col_i = 4'(4'hc - CELL_COL); // bit 0 of the glyph is the rightmost dot
    glyph_on = wide_row[col_i];
    near_border = wide_above[col_i - 4'h1] | wide_above[col_i] | wide_above[col_i + 4'h1]
      | wide_row[col_i - 4'h1] | wide_row[col_i + 4'h1]
      | wide_below[col_i - 4'h1] | wide_below[col_i] | wide_below[col_i + 4'h1]; // R3
    near_shadow = wide_row[col_i + 4'h1] | wide_above[col_i]
      | wide_above[col_i + 4'h1]; // R4
  end

  // cell ring and fade/scroll gates
  always_comb begin
    ring = (ring_dist(CELL_X, COLS) > ring_dist({1'b0, CELL_Y}, ROWS))
      ? ring_dist(CELL_X, COLS) : ring_dist({1'b0, CELL_Y}, ROWS); // R6
    fade_target = q.fc0[DISP_ON_BIT] ? MAX_RING : '0;
    fade_ratio = q.fc0[FADE_TIME_BIT] ? FADE_DIV_SHORT : FADE_DIV_LONG; // R7
    // rise counts once stages two and three agree high while the filtered level is low
    vp_edge = (q.vp_s[1] == q.vp_s[2]) && q.vp_s[2] && !q.vp_f; // R8
    // reveal shows lines above the count, erase hides them
    if (q.fc0[DISP_ON_BIT]) scroll_vis = (CELL_LINE < q.scroll); // R5
    else scroll_vis = (CELL_LINE >= q.scroll); // R5
  end

  // all state in one next-state process
  always_comb begin
    d = q;
    // synchronisers: a change counts once stages two and three agree
    d.hf_s = {q.hf_s[1:0], HORIZ_FLYBACK_REF};
    d.vp_s = {q.vp_s[1:0], VERT_PULSE};
    if (q.hf_s[1] == q.hf_s[2]) d.hf_f = q.hf_s[2];
    if (q.vp_s[1] == q.vp_s[2]) d.vp_f = q.vp_s[2];
    d.ref_edge = d.hf_f && !q.hf_f; // R9
    // line period check against the lock range
    if (q.ref_edge) begin
      d.line_cnt = '0;
      d.line_ok = (q.line_cnt >= LINE_LO) && (q.line_cnt <= LINE_HI); // R9
    end else if (q.line_cnt <= LINE_HI) begin
      d.line_cnt = q.line_cnt + CNT_W'(1);
    end else begin
      d.line_ok = 1'b0; // flyback lost
    end
    // register writes
    if (WR) begin
      unique case (ADDR)
        REG_FC0: d.fc0 = WDATA;
        REG_FC1: d.fc1 = WDATA; // R11 R12 R15
        default: ; // unmapped and status writes are dropped
      endcase
    end
    // register reads, answer stands one cycle after the strobe
    d.rdata = '0;
    if (RD) begin
      unique case (ADDR)
        REG_FC0: d.rdata = q.fc0;
        REG_FC1: d.rdata = q.fc1;
        REG_STAT: d.rdata = {1'b0, pll.pump_oe, pll.pump_src, q.line_ok,
          q.radius != fade_target, q.scroll, q.radius[5:0]};
        default: d.rdata = '0;
      endcase
    end
    // display switch: fade walks from its current radius, scroll restarts
    d.disp_prev = q.fc0[DISP_ON_BIT];
    if (q.disp_prev != q.fc0[DISP_ON_BIT]) begin
      d.fade_div = '0;
      d.scroll = q.fc0[SCROLL_EN_BIT] ? 5'h00 : CELL_LINES;
    end else if (vp_edge) begin
      if (q.scroll < CELL_LINES) d.scroll = q.scroll + 5'h01; // R5
      if (q.fade_div >= fade_ratio - 4'h1) begin
        d.fade_div = '0; // R8
        if (q.radius < fade_target) d.radius = q.radius + RING_W'(1); // R16
        else if (q.radius > fade_target) d.radius = q.radius - RING_W'(1); // R16
      end else begin
        d.fade_div = q.fade_div + 4'h1; // R8
      end
    end
    if (!q.fc0[FADE_EN_BIT]) d.radius = fade_target; // no fade: whole screen at once
    if (!q.fc0[SCROLL_EN_BIT]) d.scroll = CELL_LINES;
    // pixel stage
    d.vis = PIXEL_VALID && (ring < q.radius) && scroll_vis; // R6
    d.lit = d.vis && glyph_on;
    d.black = d.vis && !glyph_on && ((q.fc0[BORDER_BIT] && near_border)
      || (q.fc0[SHADOW_BIT] && near_shadow)); // R2
    d.box = d.vis && BOX_ENABLE && (CELL_COL == EDGE_COL_FIRST || CELL_COL == EDGE_COL_LAST
      || CELL_LINE == EDGE_LINE_FIRST || CELL_LINE == EDGE_LINE_LAST); // R1
  end

  // state register
  always_ff @(posedge CLOCK) begin
    if (!RESETN) begin
      q <= '0;
      q.fc0 <= FC0_RST;
      q.fc1 <= FC1_RST;
      q.scroll <= CELL_LINES;
    end else begin
      q <= d;
    end
  end

  // divider and phase detector run on the vco clock
  assign pll.ref_edge = q.ref_edge; // R9
  assign pll.dot_sel = q.fc1[DOT_LSB +: 2]; // R10

  dot_pll_ctrl u_pll (
    .clk(CLOCK), // R13
    .rst_n(RESETN),
    .pll(pll)
  );

  assign RDATA = q.rdata;
  assign PIXEL_LIT = q.lit;
  assign PIXEL_BLACK = q.black;
  assign BOX_EDGE = q.box;
  assign CELL_VISIBLE = q.vis;
  assign LINE_RATE_RANGE_SEL = q.fc1[HF_LSB +: 3]; // R11
  assign PUMP_CURRENT_SEL = q.fc1[CP_LSB +: 2]; // R12
  assign PLL_AUX_SELECT = q.fc1[AUX_BIT];
  assign PUMP_OUTPUT_O = pll.pump_src; // R14
  assign PUMP_OUTPUT_OE = pll.pump_oe; // R14

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RESETN);

  sequence vp_rise_s;
    !q.vp_f ##1 q.vp_f;
  endsequence
  sequence steady_on_s;
    q.fc0[FADE_EN_BIT] && q.fc0[DISP_ON_BIT] && q.disp_prev && !WR;
  endsequence

  box_edge_a: assert property (PIXEL_VALID && BOX_ENABLE && (ring < q.radius) // R1
    && scroll_vis && CELL_COL == 4'hb |=> BOX_EDGE) else $error("box edge missed");
  box_inner_a: assert property (CELL_COL == 4'h5 && CELL_LINE == 5'h09 // R1
    |=> !BOX_EDGE) else $error("box drawn inside cell");
  black_lit_a: assert property (PIXEL_BLACK |-> !PIXEL_LIT && CELL_VISIBLE) // R2
    else $error("black effect over lit dot");
  border_ring_a: assert property (PIXEL_VALID && (ring < q.radius) && scroll_vis // R3
    && q.fc0[BORDER_BIT] && !glyph_on && near_border |=> PIXEL_BLACK)
    else $error("border dot missing");
  shadow_dot_a: assert property (PIXEL_VALID && (ring < q.radius) && scroll_vis // R4
    && q.fc0[SHADOW_BIT] && !glyph_on && wide_above[col_i] |=> PIXEL_BLACK)
    else $error("shadow dot missing");
  scroll_step_a: assert property (q.fc0[SCROLL_EN_BIT] && !WR && q.disp_prev // R5
    == q.fc0[DISP_ON_BIT] && q.scroll < CELL_LINES ##0 vp_rise_s
    |-> q.scroll == $past(q.scroll) + 5'h01) else $error("scroll did not advance");
  fade_hidden_a: assert property (PIXEL_VALID && ring >= q.radius |=> !CELL_VISIBLE) // R6
    else $error("cell shown outside fade ring");
  fade_pace_a: assert property (steady_on_s ##0 vp_rise_s ##0 (q.fade_div == 4'h0) // R8
    |-> q.radius == $past(q.radius) || q.radius == $past(q.radius) + RING_W'(1))
    else $error("fade moved more than one ring");
  fade_ratio_a: assert property (q.fade_div <= FADE_DIV_LONG - 4'h1) // R7
    else $error("fade divider overran");
  ref_pulse_a: assert property (q.ref_edge |=> !q.ref_edge) // R9
    else $error("flyback edge longer than one cycle");
  range_bits_a: assert property (WR && ADDR == REG_FC1 // R11
    |=> LINE_RATE_RANGE_SEL == $past(WDATA[12:10]) && PUMP_CURRENT_SEL == $past(WDATA[14:13]))
    else $error("pll control bits not taken");
endmodule // osd_fx_top
`default_nettype wire

// >>> bench/host_mcu_model.sv
// Purpose: host microcontroller model that programs the frame control registers
// Assumes: plain register port, read data valid only in the cycle after the read strobe
// Notes: every bus signal moves by non-blocking assignment right after a rising edge
`timescale 1ns/10ps
`default_nettype none
module host_mcu_model (
  input wire logic clk,
  output logic [osd_fx_pkg::ADDR_W-1:0] addr,
  output logic [osd_fx_pkg::DATA_W-1:0] wdata,
  output logic wr,
  output logic rd,
  input wire logic [osd_fx_pkg::DATA_W-1:0] rdata
);
  import osd_fx_pkg::*;
  // recommended pll bytes, slowest line band first, 800-dot mode
  logic [7:0] pll_tab [4] = '{8'h0b, 8'h93, 8'h97, 8'h9f};
  // bus idle from time zero
  initial begin
    addr = 8'h00;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
  end
  // one-cycle write strobe beside address and data
  task automatic write_reg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // read data taken in the cycle after the strobe, the only cycle it stands
  task automatic read_reg(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  // table columns cp1 cp0 aux hf2..hf0 dot1 dot0 placed on their register bits
  task automatic program_pll(input int idx);
    logic [7:0] b;
    b = pll_tab[idx];
    write_reg(REG_FC1, {b[5], b[7:6], b[4:2], b[1:0], 8'h00});
  endtask
endmodule // host_mcu_model
`default_nettype wire

// >>> bench/osd_effects_and_dot_clock_pll_tb_top.sv
// Purpose: self-checking bench for the osd effects and pixel pll control
// Assumes: default screen of 30 x 15 cells, fade disabled means immediate
// Notes: expectations come from bench functions, never from the design outputs
`timescale 1ns/10ps
`default_nettype none
module osd_effects_and_dot_clock_pll_tb_top;
  import osd_fx_pkg::*;
  logic clock = 1'b0; // 100 MHz
  logic resetn = 1'b0; // active low
  logic hfly = 1'b0; // flyback pin
  logic vpulse = 1'b0; // vertical pulse pin
  logic valid = 1'b0;
  logic box = 1'b0;
  logic [3:0] col = 4'h0;
  logic [4:0] line = 5'h00;
  logic [5:0] cx = 6'h00;
  logic [4:0] cy = 5'h00;
  logic [11:0] g_a = 12'h000;
  logic [11:0] g_r = 12'h000;
  logic [11:0] g_b = 12'h000;
  logic lit, blk, box_edge, vis, aux, p_o, p_oe;
  logic [2:0] hf;
  logic [1:0] cp;
  logic [7:0] addr;
  logic [15:0] wdata, rdata, d;
  logic wr, rd, bd, sh;
  logic [7:0] b;
  int n_errors = 0;
  int n_compared = 0;
  int seed = 88642;
  int c, l, div;
  time t0;
  // clock
  always #5 clock = ~clock;
  osd_fx_top uut (.CLOCK(clock), .RESETN(resetn), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .HORIZ_FLYBACK_REF(hfly), .VERT_PULSE(vpulse),
    .PIXEL_VALID(valid), .BOX_ENABLE(box), .CELL_COL(col), .CELL_LINE(line), .CELL_X(cx),
    .CELL_Y(cy), .GLYPH_ABOVE(g_a), .GLYPH_ROW(g_r), .GLYPH_BELOW(g_b), .PIXEL_LIT(lit),
    .PIXEL_BLACK(blk), .BOX_EDGE(box_edge), .CELL_VISIBLE(vis), .LINE_RATE_RANGE_SEL(hf),
    .PUMP_CURRENT_SEL(cp), .PLL_AUX_SELECT(aux), .PUMP_OUTPUT_O(p_o),
    .PUMP_OUTPUT_OE(p_oe));
  host_mcu_model host (.clk(clock), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata));
  // single comparison point
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  // verdict and end of run
  task automatic finish_test;
    $display("counts: %0d compared, %0d mismatched", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // glyph dot, zero outside the cell so effects never cross an edge
  function automatic logic nb(input logic [11:0] r, input int k);
    return (k >= 0 && k <= 11) ? r[11-k] : 1'b0;
  endfunction
  // one dot in, its four outputs checked a cycle later
  task automatic dot(input int k, input int ln, input int x, input int y,
    input logic [11:0] a, input logic [11:0] r, input logic [11:0] bl, input logic bx,
    input logic pv, input logic v);
    logic lt, br, sd, eg, ok;
    @(posedge clock);
    valid <= pv;
    box <= bx;
    col <= 4'(k);
    line <= 5'(ln);
    cx <= 6'(x);
    cy <= 5'(y);
    g_a <= a;
    g_r <= r;
    g_b <= bl;
    lt = nb(r, k);
    br = nb(a, k-1) | nb(a, k) | nb(a, k+1) | nb(r, k-1) | nb(r, k+1);
    br = br | nb(bl, k-1) | nb(bl, k) | nb(bl, k+1);
    sd = nb(r, k-1) | nb(a, k) | nb(a, k-1);
    eg = (k == 0 || k == 11 || ln == 0 || ln == 17);
    ok = v & pv;
    @(posedge clock);
    #1;
    check(16'(vis), 16'(ok));
    check(16'(lit), 16'(ok & lt));
    check(16'(blk), 16'(ok & ~lt & ((bd & br) | (sh & sd))));
    check(16'(box_edge), 16'(ok & bx & eg));
  endtask
  // vertical pulses, long enough for the pin synchroniser
  task automatic pulses(input int n);
    repeat (n) begin
      @(posedge clock);
      vpulse <= 1'b1;
      repeat (3) @(posedge clock);
      vpulse <= 1'b0;
      repeat (4) @(posedge clock);
    end
  endtask
  // one flyback pulse
  task automatic fly;
    @(posedge clock);
    hfly <= 1'b1;
    repeat (3) @(posedge clock);
    hfly <= 1'b0;
  endtask
  // bounded wait for a pump state; o matters only while driving
  task automatic wait_pump(input logic oe, input logic o);
    int i;
    for (i = 0; i < 2000; i++) begin
      @(posedge clock);
      #1;
      if (p_oe === oe && (!oe || p_o === o)) break;
    end
    check(16'(i < 2000), 16'h0001);
  endtask
  // watchdog well past the expected run length
  initial begin
    #500000;
    n_errors++;
    $display("unexpected at %0t: watchdog expired", $time);
    finish_test();
  end
  // main sequence
  initial begin
    repeat (4) @(posedge clock);
    resetn <= 1'b1;
    host.read_reg(REG_FC0, d);
    check(d, FC0_RST);
    host.read_reg(REG_FC1, d);
    check(d, FC1_RST);
    host.read_reg(8'h20, d);
    check(d, 16'h0000);
    // recommended bytes, then random upper bytes
    for (int i = 0; i < 12; i++) begin
      b = (i < 4) ? host.pll_tab[i] : 8'($random(seed));
      host.write_reg(REG_FC1, {b[5], b[7:6], b[4:2], b[1:0], 8'h00});
      #1;
      check(16'(hf), 16'(b[4:2]));
      check(16'(cp), 16'(b[7:6]));
      check(16'(aux), 16'(b[5]));
      host.read_reg(REG_FC1, d);
      check(d, {b[5], b[7:6], b[4:2], b[1:0], 8'h00});
    end
    $display("register test done");
    // every border and shadow mode with random dots, one refused dot each
    for (int m = 0; m < 4; m++) begin
      bd = m[0];
      sh = m[1];
      host.write_reg(REG_FC0, 16'(1 | (m << BORDER_BIT)));
      dot(0, 0, 1, 1, 12'hfff, 12'hfff, 12'hfff, 1'b1, 1'b0, 1'b1);
      repeat (30) begin
        c = {$random(seed)} % 12;
        l = {$random(seed)} % 18;
        dot(c, l, {$random(seed)} % 30, {$random(seed)} % 15, (l == 0) ? 12'h000 :
          12'($random(seed)), 12'($random(seed)), (l == 17) ? 12'h000 : 12'($random(seed)),
          1'($random(seed)), 1'b1, 1'b1);
      end
    end
    bd = 1'b0;
    sh = 1'b0;
    $display("pixel test done");
    // fade in both speeds, centre outward, one ring per step
    for (int ft = 1; ft >= 0; ft--) begin
      div = ft ? 4 : 8;
      host.write_reg(REG_FC0, 16'h0000);
      host.write_reg(REG_FC0, 16'(3 | (ft << FADE_TIME_BIT)));
      pulses(div / 2);
      for (int k = 1; k < 3; k++) begin
        pulses(div);
        host.read_reg(REG_STAT, d);
        check(16'(d[5:0]), 16'(k));
        check(16'(d[11]), 16'h0001);
      end
      dot(5, 5, 15, 7, 0, 0, 0, 1'b1, 1'b1, 1'b1);
      dot(5, 5, 0, 0, 0, 0, 0, 1'b1, 1'b1, 1'b0);
      host.write_reg(REG_FC0, 16'(2 | (ft << FADE_TIME_BIT)));
      pulses(div + div / 2);
      host.read_reg(REG_STAT, d);
      check(16'(d[5:0]), 16'h0001);
    end
    host.write_reg(REG_FC0, 16'h0001);
    dot(5, 5, 0, 0, 0, 0, 0, 1'b1, 1'b1, 1'b1);
    host.write_reg(REG_FC0, 16'h0000);
    $display("fade test done");
    // scroll reveals from the top line down
    host.write_reg(REG_FC0, 16'(1 | (1 << SCROLL_EN_BIT)));
    pulses(3);
    dot(4, 0, 3, 3, 0, 12'hfff, 0, 1'b0, 1'b1, 1'b1);
    dot(4, 17, 3, 3, 0, 12'hfff, 0, 1'b0, 1'b1, 1'b0);
    $display("scroll test done");
    // divider period between sink starts, then source from idle
    for (int s = 0; s < 4; s++) begin
      host.write_reg(REG_FC1, 16'(s << DOT_LSB));
      fly();
      wait_pump(1'b1, 1'b0);
      fly();
      wait_pump(1'b0, 1'b0);
      wait_pump(1'b1, 1'b0);
      t0 = $time;
      fly();
      wait_pump(1'b0, 1'b0);
      wait_pump(1'b1, 1'b0);
      check(16'(($time - t0) / 10), 16'(320 + 160 * s));
      fly();
      wait_pump(1'b0, 1'b0);
      fly();
      repeat (4) @(posedge clock);
      #1;
      check(16'({p_oe, p_o}), 16'h0003);
    end
    $display("pump test done");
    finish_test();
  end
endmodule // osd_effects_and_dot_clock_pll_tb_top
`default_nettype wire
